// *** pkg/rsc_pkg.sv ***
// Shared constants, types and helpers of the reset source controller.
package rsc_pkg;

  // ****************************************************************
  // Register map and field positions
  // ****************************************************************
  localparam logic [7:0] ADR_GUARD   = 8'h00;
  localparam logic [7:0] ADR_CAUSE   = 8'h04;
  localparam logic [7:0] ADR_LEVEL   = 8'h08;
  localparam logic [7:0] ADR_FILTER  = 8'h0C;
  localparam int         FLAG_GUARD  = 3;
  localparam int         FLAG_BO     = 2;
  localparam int         FLAG_LVLCFG = 1;
  localparam int         FLAG_WDT    = 0;

  // ****************************************************************
  // Codes and reset values
  // ****************************************************************
  localparam logic [7:0] GUARD_IO    = 8'h55;
  localparam logic [7:0] GUARD_PIN   = 8'hAA;
  localparam logic [7:0] LVL_1V70    = 8'h66;
  localparam logic [7:0] LVL_1V90    = 8'h55;
  localparam logic [7:0] LVL_2V55    = 8'h33;
  localparam logic [7:0] LVL_3V15    = 8'h99;
  localparam logic [7:0] LVL_3V80    = 8'hAA;
  localparam logic [7:0] LVL_OFF     = 8'hF0;
  localparam logic [7:0] LVL_POR     = LVL_1V70;
  localparam logic [1:0] FILT_POR    = 2'h1;
  localparam logic [3:0] FLAGS_POR   = 4'h0;

  // ****************************************************************
  // Timing counts in clock cycles and sub-clock periods
  // ****************************************************************
  localparam int         SRESET_CYCLES = 64;
  localparam int         RSTD_CYCLES   = 256;
  localparam int         PULSE_CYCLES  = 8;
  localparam logic [7:0] FILT_LIM0     = 8'h08;
  localparam logic [7:0] FILT_LIM1     = 8'h20;
  localparam logic [7:0] FILT_LIM2     = 8'h40;
  localparam logic [7:0] FILT_LIM3     = 8'h80;

  // ****************************************************************
  // Types and helpers
  // ****************************************************************
  typedef enum logic [2:0] {
    RSC_PULSE,
    RSC_RUN,
    RSC_ARM,
    RSC_PIN_HOLD,
    RSC_PIN_DELAY
  } rsc_state_t;

  function automatic logic rsc_level_ok(input logic [7:0] v);
    return (v == LVL_1V70) || (v == LVL_1V90) || (v == LVL_2V55) ||
           (v == LVL_3V15) || (v == LVL_3V80) || (v == LVL_OFF);
  endfunction : rsc_level_ok

  function automatic logic [2:0] rsc_level_idx(input logic [7:0] v);
    case (v)
      LVL_1V90: return 3'h1;
      LVL_2V55: return 3'h2;
      LVL_3V15: return 3'h3;
      LVL_3V80: return 3'h4;
      default:  return 3'h0;
    endcase
  endfunction : rsc_level_idx

endpackage : rsc_pkg

// *** pkg/rsc_bo_if.sv ***
// Carrier between the controller and its brown-out filter.
`timescale 1ns/100ps
interface rsc_bo_if;
  logic       enable;
  logic [1:0] filt_sel;
  logic       low_supply;
  logic       sub_tick;
  logic       trip;

  modport ctl (
    output enable,
    output filt_sel,
    output low_supply,
    output sub_tick,
    input  trip
  );

  modport flt (
    input  enable,
    input  filt_sel,
    input  low_supply,
    input  sub_tick,
    output trip
  );
endinterface : rsc_bo_if

// *** rtl/rsc_sync3.sv ***
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/100ps
module rsc_sync3 #(
  parameter logic INIT = 1'b1
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Data
  input  wire logic din,
  output logic      dout
);

  typedef struct packed {
    logic ff1;
    logic ff2;
    logic ff3;
    logic stable;
  } rsc_sync_t;

  rsc_sync_t s_q;
  rsc_sync_t s_d;

  // A change is believed only once the two settled stages agree.
  always_comb begin
    s_d = s_q;
    s_d.ff1 = din;
    s_d.ff2 = s_q.ff1;
    s_d.ff3 = s_q.ff2;
    if (s_q.ff2 == s_q.ff3) begin
      s_d.stable = s_q.ff3;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '{ff1: INIT, ff2: INIT, ff3: INIT, stable: INIT};
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.stable;

endmodule : rsc_sync3

// *** rtl/rsc_bo_filter.sv ***
// Brown-out duration filter counting sub-clock periods of low supply.
`timescale 1ns/100ps
module rsc_bo_filter (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Controller side
  rsc_bo_if.flt     bo
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       trip;
  } rsc_filt_t;

  rsc_filt_t  s_q;
  rsc_filt_t  s_d;
  logic [7:0] limit;

  always_comb begin
    case (bo.filt_sel)
      2'h0:    limit = rsc_pkg::FILT_LIM0;
      2'h1:    limit = rsc_pkg::FILT_LIM1;
      2'h2:    limit = rsc_pkg::FILT_LIM2;
      default: limit = rsc_pkg::FILT_LIM3;
    endcase
  end

  // The first period is partial, so the real width is limit-1 to limit.
  always_comb begin
    s_d = s_q;
    s_d.trip = 1'b0;
    if (!bo.enable || !bo.low_supply) begin
      s_d.cnt = 8'h00;
    end else if (bo.sub_tick) begin
      if (s_q.cnt == limit - 8'h01) begin
        s_d.cnt = 8'h00;
        s_d.trip = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '{cnt: 8'h00, trip: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign bo.trip = s_q.trip;

endmodule : rsc_bo_filter

// *** rtl/rsc_top.sv ***
// Reset source controller with brown-out supervisor and Wishbone registers.
`timescale 1ns/100ps
module rsc_top #(
  parameter int SRESET_CYCLES = rsc_pkg::SRESET_CYCLES,
  parameter int RSTD_CYCLES   = rsc_pkg::RSTD_CYCLES,
  parameter int PULSE_CYCLES  = rsc_pkg::PULSE_CYCLES
) (
  // Clock and power-on reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Pins and analog inputs
  input  wire logic        external_clear_pin_n,
  input  wire logic        low_supply_raw,
  input  wire logic        sub_clk_raw,
  // Core side
  input  wire logic        sleep_idle,
  input  wire logic        other_reset_req,
  input  wire logic        watchdog_cfg_fault,
  output logic             sys_reset,
  output logic             port_preset,
  output logic             pin_reset_func,
  output logic             brownout_enable,
  output logic [2:0]       brownout_threshold_sel
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    rsc_pkg::rsc_state_t state;
    logic [15:0]         cnt;
    logic [7:0]          guard;
    logic [7:0]          level;
    logic [1:0]          filt;
    logic [3:0]          flags;
    logic                cause_g;
    logic                cause_l;
    logic                por;
    logic                ack;
    logic [7:0]          dat;
    logic                sys_reset;
    logic                port_preset;
    logic                pin_func;
    logic                bo_en;
    logic [2:0]          lvl_sel;
    logic                sub_prev;
  } rsc_top_t;

  rsc_top_t s_q;
  rsc_top_t s_d;

  logic     pin_n_s;
  logic     low_s;
  logic     sub_s;
  rsc_bo_if bo ();

  // ****************************************************************
  // Pin synchronisers and brown-out filter
  // ****************************************************************
  rsc_sync3 #(.INIT(1'b1)) u_sync_pin (
    .clk   (clk),
    .reset (reset),
    .din   (external_clear_pin_n),
    .dout  (pin_n_s)
  );

  rsc_sync3 #(.INIT(1'b0)) u_sync_low (
    .clk   (clk),
    .reset (reset),
    .din   (low_supply_raw),
    .dout  (low_s)
  );

  rsc_sync3 #(.INIT(1'b0)) u_sync_sub (
    .clk   (clk),
    .reset (reset),
    .din   (sub_clk_raw),
    .dout  (sub_s)
  );

  // filter field and threshold steer the supervisor
  assign bo.enable     = s_q.bo_en;
  assign bo.filt_sel   = s_q.filt;
  assign bo.low_supply = low_s;
  assign bo.sub_tick   = sub_s & ~s_q.sub_prev;

  rsc_bo_filter u_filter (
    .clk   (clk),
    .reset (reset),
    .bo    (bo)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic       acc;
    logic       wr;
    logic       guard_bad;
    logic       lvl_bad;
    logic       pin_low;
    logic       go_pulse;
    logic [3:0] set;
    logic [3:0] clr;
    acc = 1'b0;
    wr = 1'b0;
    guard_bad = 1'b0;
    lvl_bad = 1'b0;
    pin_low = 1'b0;
    go_pulse = 1'b0;
    set = 4'h0;
    clr = 4'h0;
    s_d = s_q;
    s_d.sub_prev = sub_s;

    // Bus: answer one cycle after the request, drop ack the next cycle.
    acc = wb_cyc_i & wb_stb_i & ~s_q.ack;
    wr = acc & wb_we_i & wb_sel_i[0];
    s_d.ack = acc;
    s_d.dat = 8'h00;
    if (acc && !wb_we_i) begin
      case (wb_adr_i)
        rsc_pkg::ADR_GUARD:  s_d.dat = s_q.guard;
        rsc_pkg::ADR_CAUSE:  s_d.dat = {4'h0, s_q.flags};
        rsc_pkg::ADR_LEVEL:  s_d.dat = s_q.level;
        rsc_pkg::ADR_FILTER: s_d.dat = {6'h00, s_q.filt};
        default:             s_d.dat = 8'h00;
      endcase
    end
    if (wr) begin
      case (wb_adr_i)
        rsc_pkg::ADR_GUARD:  s_d.guard = wb_dat_i[7:0];
        rsc_pkg::ADR_CAUSE:  clr = ~wb_dat_i[3:0];
        rsc_pkg::ADR_LEVEL:  s_d.level = wb_dat_i[7:0];
        rsc_pkg::ADR_FILTER: s_d.filt = wb_dat_i[1:0];
        default:             clr = 4'h0;
      endcase
    end

    guard_bad = (s_q.guard != rsc_pkg::GUARD_IO) &&
                (s_q.guard != rsc_pkg::GUARD_PIN);
    lvl_bad = !rsc_pkg::rsc_level_ok(s_q.level);
    pin_low = (s_q.guard == rsc_pkg::GUARD_PIN) && !pin_n_s;
    set[rsc_pkg::FLAG_WDT] = watchdog_cfg_fault;

    if (bo.trip && s_q.state != rsc_pkg::RSC_PULSE) begin
      set[rsc_pkg::FLAG_BO] = 1'b1;
      go_pulse = 1'b1;
    end else begin
      case (s_q.state)
        rsc_pkg::RSC_RUN: begin
          if (pin_low) begin
            s_d.state = rsc_pkg::RSC_PIN_HOLD;
          end else if (guard_bad || lvl_bad) begin
            s_d.state = rsc_pkg::RSC_ARM;
            s_d.cnt = 16'h0000;
            s_d.cause_g = guard_bad;
            s_d.cause_l = lvl_bad;
          end else if (other_reset_req) begin
            go_pulse = 1'b1;
          end
        end
        rsc_pkg::RSC_ARM: begin
          if (s_q.cnt == 16'(SRESET_CYCLES - 1)) begin
            set[rsc_pkg::FLAG_GUARD] = s_q.cause_g;
            set[rsc_pkg::FLAG_LVLCFG] = s_q.cause_l;
            go_pulse = 1'b1;
          end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
          end
        end
        rsc_pkg::RSC_PIN_HOLD: begin
          if (!pin_low) begin
            s_d.state = rsc_pkg::RSC_PIN_DELAY;
            s_d.cnt = 16'h0000;
          end
        end
        rsc_pkg::RSC_PIN_DELAY: begin
          if (pin_low) begin
            s_d.state = rsc_pkg::RSC_PIN_HOLD;
          end else if (s_q.cnt == 16'(RSTD_CYCLES - 1)) begin
            s_d.state = rsc_pkg::RSC_RUN;
            s_d.guard = rsc_pkg::GUARD_IO;
          end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
          end
        end
        rsc_pkg::RSC_PULSE: begin
          if (s_q.cnt == 16'(PULSE_CYCLES - 1)) begin
            s_d.state = rsc_pkg::RSC_RUN;
            s_d.por = 1'b0;
          end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
          end
        end
        default: begin
          s_d.state = rsc_pkg::RSC_RUN;
        end
      endcase
    end

    if (go_pulse) begin
      s_d.state = rsc_pkg::RSC_PULSE;
      s_d.cnt = 16'h0000;
      s_d.guard = rsc_pkg::GUARD_IO;
      // A brown-out reset keeps the level; a level fault restores it.
      if (s_q.state == rsc_pkg::RSC_ARM && s_q.cause_l) begin
        s_d.level = rsc_pkg::LVL_POR;
      end
    end

    s_d.flags = (s_q.flags & ~clr) | set;

    // Outputs are registered from the next state.
    s_d.sys_reset = s_d.state != rsc_pkg::RSC_RUN;
    s_d.port_preset = s_d.por;
    s_d.pin_func = s_d.guard == rsc_pkg::GUARD_PIN;
    s_d.bo_en = !sleep_idle && (s_d.level != rsc_pkg::LVL_OFF) &&
                rsc_pkg::rsc_level_ok(s_d.level);
    s_d.lvl_sel = rsc_pkg::rsc_level_idx(s_d.level);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q.state       <= rsc_pkg::RSC_PULSE;
      s_q.cnt         <= 16'h0000;
      s_q.guard       <= rsc_pkg::GUARD_IO;
      s_q.level       <= rsc_pkg::LVL_POR;
      s_q.filt        <= rsc_pkg::FILT_POR;
      s_q.flags       <= rsc_pkg::FLAGS_POR;
      s_q.cause_g     <= 1'b0;
      s_q.cause_l     <= 1'b0;
      s_q.por         <= 1'b1;
      s_q.ack         <= 1'b0;
      s_q.dat         <= 8'h00;
      s_q.sys_reset   <= 1'b1;
      s_q.port_preset <= 1'b1;
      s_q.pin_func    <= 1'b0;
      s_q.bo_en       <= 1'b1;
      s_q.lvl_sel     <= 3'h0;
      s_q.sub_prev    <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_dat_o               = {24'h000000, s_q.dat};
  assign wb_ack_o               = s_q.ack;
  assign sys_reset              = s_q.sys_reset;
  assign port_preset            = s_q.port_preset;
  assign pin_reset_func         = s_q.pin_func;
  assign brownout_enable        = s_q.bo_en;
  assign brownout_threshold_sel = s_q.lvl_sel;

endmodule : rsc_top

// *** bench/rsc_top_sva.sv ***
// Port checks of the reset source controller.
`timescale 1ns/100ps
module rsc_chk #(
  parameter int SRESET_CYCLES = rsc_pkg::SRESET_CYCLES
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // Register bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Pins and core
  input wire logic        external_clear_pin_n,
  input wire logic        sleep_idle,
  input wire logic        sys_reset,
  input wire logic        port_preset,
  input wire logic        pin_reset_func,
  input wire logic        brownout_enable,
  input wire logic [2:0]  brownout_threshold_sel
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  localparam int SR_LO = SRESET_CYCLES - 1;
  localparam int SR_HI = SRESET_CYCLES + 3;
  logic       wr_ok;
  logic [7:0] wd;
  // A bad value written in a reset state waits for the run state; untimed.
  assign wr_ok = wb_ack_o && wb_we_i && wb_sel_i[0] && !sys_reset;
  assign wd = wb_dat_i[7:0];
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_cause_upper: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == rsc_pkg::ADR_CAUSE
    |-> wb_dat_o[7:4] == 4'h0) else $error("cause upper bits set");
  a_guard_fault: assert property (
    wr_ok && wb_adr_i == rsc_pkg::ADR_GUARD && wd != rsc_pkg::GUARD_IO &&
    wd != rsc_pkg::GUARD_PIN |-> ##[SR_LO:SR_HI] sys_reset)
    else $error("bad guard gave no reset");
  a_pin_select: assert property (
    wr_ok && wb_adr_i == rsc_pkg::ADR_GUARD && wd == rsc_pkg::GUARD_PIN
    |-> ##[1:2] pin_reset_func) else $error("pin function not selected");
  a_pin_reset: assert property (
    (pin_reset_func && !external_clear_pin_n) [*4] |-> ##[0:4] sys_reset)
    else $error("low pin gave no reset");
  a_pin_hold: assert property (
    pin_reset_func && sys_reset && $rose(external_clear_pin_n)
    |-> sys_reset [*8]) else $error("release delay too short");
  a_sleep_off: assert property (
    sleep_idle ##1 sleep_idle |-> !brownout_enable)
    else $error("supervisor on in sleep");
  a_level_sel: assert property (
    wr_ok && wb_adr_i == rsc_pkg::ADR_LEVEL && wd == rsc_pkg::LVL_3V80
    |-> ##[1:2] brownout_threshold_sel == 3'h4)
    else $error("threshold select wrong");
  a_preset_rst: assert property (port_preset |-> sys_reset)
    else $error("port preset outside reset");
  c_pin_rst: cover property ($fell(external_clear_pin_n) && pin_reset_func);
  c_sys_rst: cover property ($rose(sys_reset));
  c_sleep: cover property (sleep_idle && !brownout_enable);
endmodule : rsc_chk

// *** bench/rsc_far_model.sv ***
// Model of the reset pin driver, supply comparator and sub-clock source.
`timescale 1ns/100ps
module rsc_far_model #(
  parameter int SUB_HALF = 8
) (
  // Clock and commands
  input  wire logic clk,
  input  wire logic pin_low,
  input  wire logic supply_low,
  // Far-side pins
  output logic      external_clear_pin_n,
  output logic      low_supply_raw,
  output logic      sub_clk_raw = 1'h0
);
  int div_q = 0;
  // The sub oscillator runs free and far slower than clk.
  always @(posedge clk) begin
    div_q <= (div_q == SUB_HALF - 1) ? 0 : div_q + 1;
    if (div_q == SUB_HALF - 1) begin
      sub_clk_raw <= ~sub_clk_raw;
    end
  end
  // pin pulled low
  // The pin has a pull-up, so a released line reads high.
  assign external_clear_pin_n = ~pin_low;
  assign low_supply_raw = supply_low;
endmodule : rsc_far_model

// *** bench/rsc_top_tb.sv ***
// Self-checking bench of the reset source controller.
`timescale 1ns/100ps
module rsc_top_tb;
  localparam int SR = 4;
  localparam int RD = 8;
  logic        clk = 1'h0, reset = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic        sleep = 1'h0, oreq = 1'h0, wdt = 1'h0;
  logic        pin_low = 1'h0, sup_low = 1'h0;
  logic [31:0] rdat;
  logic        ack, pin_n, low_raw, sub_raw, sys_rst, preset, pin_func, bo_en;
  logic [2:0]  thr;
  int          err_total = 0;
  int          checks = 0;

  rsc_top #(.SRESET_CYCLES(SR), .RSTD_CYCLES(RD), .PULSE_CYCLES(4)) u_dut (
    .clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .external_clear_pin_n(pin_n),
    .low_supply_raw(low_raw), .sub_clk_raw(sub_raw), .sleep_idle(sleep),
    .other_reset_req(oreq), .watchdog_cfg_fault(wdt), .sys_reset(sys_rst),
    .port_preset(preset), .pin_reset_func(pin_func),
    .brownout_enable(bo_en), .brownout_threshold_sel(thr));
  rsc_far_model u_far (
    .clk(clk), .pin_low(pin_low), .supply_low(sup_low),
    .external_clear_pin_n(pin_n), .low_supply_raw(low_raw),
    .sub_clk_raw(sub_raw));
  initial forever #2 clk = ~clk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic tmo(input string nm);
    err_total++;
    $display("ERROR %s expected done seen timeout", nm);
    close_out();
  endtask : tmo
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
      if (n > 20) begin
        tmo("bus");
      end
    end while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    sel <= 4'h0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask : wr
  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [7:0] e);
    logic [31:0] q;
    bus(1'h0, a, 8'h00, q);
    chk(nm, {24'h0, e}, q);
  endtask : rd_chk
  task automatic wait_rst(input logic lvl, output int n);
    n = 0;
    while (sys_rst !== lvl) begin
      @(posedge clk);
      n++;
      if (n > 600) begin
        tmo("sys_reset");
      end
    end
  endtask : wait_rst
  task automatic low_for(input int c, output int hits);
    hits = 0;
    sup_low <= 1'h1;
    repeat (c) begin
      @(posedge clk);
      hits += (sys_rst === 1'h1);
    end
    sup_low <= 1'h0;
  endtask : low_for
  // A bad value must reset, restore the register and latch its flag.
  task automatic fault_run(input logic [7:0] a, input logic [7:0] v,
                           input logic [7:0] por, input logic [7:0] fl);
    int n;
    wr(a, v);
    wait_rst(1'h1, n);
    wait_rst(1'h0, n);
    rd_chk("restored", a, por);
    rd_chk("flag_set", rsc_pkg::ADR_CAUSE, fl);
    wr(rsc_pkg::ADR_CAUSE, 8'hFF);
    rd_chk("flag_kept", rsc_pkg::ADR_CAUSE, fl);
    wr(rsc_pkg::ADR_CAUSE, ~fl);
    rd_chk("flag_clr", rsc_pkg::ADR_CAUSE, 8'h00);
  endtask : fault_run

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_por;
    int n;
    @(posedge clk);
    chk("preset_on", 32'h1, preset);
    wait_rst(1'h0, n);
    chk("preset_off", 32'h0, preset);
    rd_chk("guard_por", rsc_pkg::ADR_GUARD, 8'h55);
    rd_chk("level_por", rsc_pkg::ADR_LEVEL, 8'h66);
    rd_chk("filt_por", rsc_pkg::ADR_FILTER, 8'h01);
    rd_chk("cause_por", rsc_pkg::ADR_CAUSE, 8'h00);
  endtask : t_por
  task automatic t_flags;
    int n;
    wdt <= 1'h1;
    @(posedge clk);
    wdt <= 1'h0;
    wr(rsc_pkg::ADR_CAUSE, 8'hFF);
    rd_chk("wdt_flag", rsc_pkg::ADR_CAUSE, 8'h01);
    wr(rsc_pkg::ADR_CAUSE, 8'hFE);
    rd_chk("wdt_clr", rsc_pkg::ADR_CAUSE, 8'h00);
    wr(rsc_pkg::ADR_GUARD, 8'hAA);
    oreq <= 1'h1;
    @(posedge clk);
    oreq <= 1'h0;
    wait_rst(1'h1, n);
    wait_rst(1'h0, n);
    rd_chk("guard_oreq", rsc_pkg::ADR_GUARD, 8'h55);
  endtask : t_flags
  task automatic t_guard;
    logic [7:0] bad [3] = '{8'h12, 8'hAB, 8'h54};
    foreach (bad[i]) begin
      fault_run(rsc_pkg::ADR_GUARD, bad[i], 8'h55, 8'h08);
    end
    fault_run(rsc_pkg::ADR_LEVEL, 8'h67, 8'h66, 8'h02);
  endtask : t_guard
  task automatic t_pin;
    int n;
    pin_low <= 1'h1;
    repeat (20) @(posedge clk);
    chk("pin_unused", 32'h0, sys_rst);
    pin_low <= 1'h0;
    // The synchronised pin lags; arming early would see a stale low.
    repeat (6) @(posedge clk);
    wr(rsc_pkg::ADR_GUARD, 8'hAA);
    repeat (2) @(posedge clk);
    chk("pin_func", 32'h1, pin_func);
    pin_low <= 1'h1;
    wait_rst(1'h1, n);
    repeat (20) @(posedge clk);
    chk("pin_hold", 32'h1, sys_rst);
    pin_low <= 1'h0;
    wait_rst(1'h0, n);
    chk("pin_delay", 32'h1, n >= RD);
    rd_chk("guard_back", rsc_pkg::ADR_GUARD, 8'h55);
    chk("pin_func_off", 32'h0, pin_func);
  endtask : t_pin
  task automatic t_bo;
    int n;
    wr(rsc_pkg::ADR_FILTER, 8'h00);
    low_for(64, n);
    chk("short_low", 32'h0, n);
    repeat (16) @(posedge clk);
    rd_chk("no_flag", rsc_pkg::ADR_CAUSE, 8'h00);
    low_for(192, n);
    chk("long_low", 32'h1, n > 0);
    repeat (16) @(posedge clk);
    wait_rst(1'h0, n);
    rd_chk("bo_flag", rsc_pkg::ADR_CAUSE, 8'h04);
    wr(rsc_pkg::ADR_CAUSE, 8'hFB);
    rd_chk("bo_clr", rsc_pkg::ADR_CAUSE, 8'h00);
    wr(rsc_pkg::ADR_FILTER, 8'h01);
    low_for(256, n);
    chk("filt1_low", 32'h0, n);
    repeat (16) @(posedge clk);
  endtask : t_bo
  task automatic t_sleep;
    logic [7:0] cd [6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0};
    logic [2:0] ex [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0};
    int n;
    foreach (cd[i]) begin
      wr(rsc_pkg::ADR_LEVEL, cd[i]);
      repeat (2) @(posedge clk);
      chk("thr_sel", ex[i], thr);
      chk("bo_en", i < 5, bo_en);
    end
    wr(rsc_pkg::ADR_FILTER, 8'h00);
    wr(rsc_pkg::ADR_LEVEL, 8'h66);
    sleep <= 1'h1;
    repeat (3) @(posedge clk);
    chk("bo_sleep", 32'h0, bo_en);
    low_for(192, n);
    chk("sleep_low", 32'h0, n);
    sleep <= 1'h0;
    repeat (3) @(posedge clk);
    chk("bo_wake", 32'h1, bo_en);
  endtask : t_sleep

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'h0;
    t_por();
    t_flags();
    t_guard();
    t_pin();
    t_bo();
    t_sleep();
    close_out();
  end
endmodule : rsc_top_tb

bind rsc_top rsc_chk #(.SRESET_CYCLES(SRESET_CYCLES)) u_chk (
  .clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .external_clear_pin_n(external_clear_pin_n), .sleep_idle(sleep_idle),
  .sys_reset(sys_reset), .port_preset(port_preset),
  .pin_reset_func(pin_reset_func), .brownout_enable(brownout_enable),
  .brownout_threshold_sel(brownout_threshold_sel));
